// ### logic/dac_ctrl_pkg.sv
package dac_ctrl_pkg;

   localparam int NUM_CH = 32;
   localparam int CODE_W = 14;
   localparam int GAIN_W = 13;
   localparam int ADDR_W = 8;
   localparam int SEL_W = 2;
   localparam int CH_W = 5;
   localparam int FIFO_DEPTH = 128;

   // Destination select of a write
   localparam logic [SEL_W-1:0] SEL_SPECIAL = 2'h0;
   localparam logic [SEL_W-1:0] SEL_GAIN = 2'h1;
   localparam logic [SEL_W-1:0] SEL_OFFSET = 2'h2;
   localparam logic [SEL_W-1:0] SEL_INPUT = 2'h3;

   // Channel addressing: 0..31 single, four groups of eight, then all
   localparam logic [ADDR_W-1:0] ADDR_GROUP_BASE = 8'h20;
   localparam logic [ADDR_W-1:0] ADDR_ALL = 8'h24;
   localparam logic [CH_W-1:0] GROUP_LAST_OFS = 5'h07;
   localparam logic [CH_W-1:0] CH_FIRST = 5'h00;
   localparam logic [CH_W-1:0] CH_LAST = 5'h1f;

   // Register defaults and transfer function constants
   localparam logic [CODE_W-1:0] CODE_MID = 14'h2000;
   localparam logic [CODE_W-1:0] CODE_FULL = 14'h3fff;
   localparam logic [CODE_W-1:0] CODE_ZERO = 14'h0000;
   localparam logic [GAIN_W-1:0] GAIN_DEFAULT = 13'h1fff;
   localparam logic [CODE_W-1:0] OFFSET_DEFAULT = 14'h2000;
   localparam int GAIN_FRAC = 13;

   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int FIFO_OVH_NS = 200;
   localparam int FIFO_OVH_CYC = FIFO_OVH_NS / CLK_PERIOD_NS;
   localparam int BUSY_1CH_FIFO_NS = 530;
   localparam int BUSY_1CH_NOFIFO_NS = 330;
   localparam int BUSY_ALL_FIFO_NS = 5500;
   localparam int BUSY_1CH_FIFO_CYC = BUSY_1CH_FIFO_NS / CLK_PERIOD_NS;
   localparam int BUSY_1CH_NOFIFO_CYC = BUSY_1CH_NOFIFO_NS / CLK_PERIOD_NS;
   localparam int BUSY_ALL_FIFO_CYC = BUSY_ALL_FIFO_NS / CLK_PERIOD_NS;
   localparam logic [7:0] OVH_LAST = 8'(FIFO_OVH_CYC - 1);

   typedef struct packed {
      logic [SEL_W-1:0] sel;
      logic [ADDR_W-1:0] addr;
      logic [CODE_W-1:0] data;
   } write_t;

   localparam int WRITE_W = $bits(write_t);

   typedef struct packed {
      logic valid;
      logic [CH_W-1:0] first;
      logic [CH_W-1:0] last;
   } ch_range_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_WAIT,
      ST_CALC
   } engine_state_t;

endpackage

// ### logic/dac_update_clear_ctrl.sv
`timescale 1ns/1ps
// How it works
// R1: While clear is low, all outputs are forced to the ground reference.
// R2: Clear leaves input codes and DAC registers untouched.
// R3: After clear releases, outputs stay grounded until the next load strobe.
// R4: Load strobe level and edges are ignored while clear is low.
// R5: Host clears by software writing a ground-yielding input code.
// R6: Each input, gain or offset write recomputes and drives busy low meanwhile.
// R7: Recompute only the addressed channel or channel group.
// R8: Writes keep being accepted while busy, but outputs never update then.
// R9: Load strobe low with busy inactive updates the outputs.
// R10: Load strobe falling during busy is stored and served when busy ends.
// R11: Load strobe held low updates outputs each time busy ends.
// R12: FIFO enabled busy limits: 530, 700, 900, 1050, 5500 ns.
// R13: FIFO disabled busy limits: 330, 500, 700, 850, 5300 ns.
// R14: FIFO enabled adds about 200 ns access overhead per instruction.
// R15: Load copies only channels whose corrected code was written since last load.
// R16: Registers load with the FIFO enabled or disabled.
// R17: With FIFO enabled, writes are taken at full speed during execution.
// R18: The write FIFO holds 128 instructions.
// R19: Writes arriving with the FIFO full are discarded.
// R20: Host may overwrite gain and offset; later recomputes use them.
// R21: Corrected = (gain+1)/8192 * input + offset - 8192, clamped.
// R22: Gain 13 bits default all ones; offset 14 bits default midscale.
// R23: Instructions run in order; busy stays low until the queue drains.
module dac_update_clear_ctrl
   import dac_ctrl_pkg::*;
(
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic wr_valid_i,
   input wire write_t wr_i,
   output logic wr_ready_o,
   output logic wr_dropped_o,
   input wire logic fifo_enable_i,
   input wire logic load_outputs_n_i,
   input wire logic output_clear_n_i,
   output logic busy_n_o,
   output logic analog_outputs_grounded_o,
   output logic [NUM_CH-1:0][CODE_W-1:0] analog_outputs_o
);

   typedef struct packed {
      logic [NUM_CH-1:0][CODE_W-1:0] input_code_reg;
      logic [NUM_CH-1:0][GAIN_W-1:0] gain;
      logic [NUM_CH-1:0][CODE_W-1:0] offset;
      logic [NUM_CH-1:0][CODE_W-1:0] corrected_code_reg;
      logic [NUM_CH-1:0][CODE_W-1:0] dac;
      logic [NUM_CH-1:0] changed;
      engine_state_t state;
      write_t instr;
      logic [CH_W-1:0] ch;
      logic [CH_W-1:0] last;
      logic [7:0] wait_cnt;
      logic pending;
      logic grounded;
      logic [1:0] load_outputs_n_sync;
      logic load_outputs_n_prev;
      logic [1:0] clr_sync;
      logic [1:0] fen_sync;
      logic busy_prev;
   } ctrl_state_t;

   localparam ctrl_state_t STATE_RESET = '{
      input_code_reg: {NUM_CH{CODE_MID}},
      gain: {NUM_CH{GAIN_DEFAULT}},
      offset: {NUM_CH{OFFSET_DEFAULT}},
      corrected_code_reg: {NUM_CH{CODE_MID}},
      dac: {NUM_CH{CODE_MID}},
      changed: '0,
      state: ST_IDLE,
      instr: '0,
      ch: CH_FIRST,
      last: CH_FIRST,
      wait_cnt: '0,
      pending: 1'b0,
      grounded: 1'b1,
      load_outputs_n_sync: 2'h3,
      load_outputs_n_prev: 1'b1,
      clr_sync: 2'h3,
      fen_sync: 2'h0,
      busy_prev: 1'b0
   };

   // Decode of a channel address into an inclusive channel range
   function automatic ch_range_t chan_range(input logic [ADDR_W-1:0] addr);
      ch_range_t r;
      r = '0;
      if (addr < ADDR_W'(NUM_CH)) begin
         r.valid = 1'b1;
         r.first = addr[CH_W-1:0];
         r.last = addr[CH_W-1:0];
      end else if (addr < ADDR_ALL) begin
         r.valid = 1'b1;
         r.first = {addr[1:0], 3'h0};
         r.last = {addr[1:0], 3'h0} + GROUP_LAST_OFS;
      end else if (addr == ADDR_ALL) begin
         r.valid = 1'b1;
         r.first = CH_FIRST;
         r.last = CH_LAST;
      end
      return r;
   endfunction

   // Gain and offset correction with saturation
   function automatic logic [CODE_W-1:0] correct(input logic [CODE_W-1:0] x1,
         input logic [GAIN_W-1:0] m, input logic [CODE_W-1:0] c);
      logic [27:0] prod;
      logic signed [17:0] sum;
      prod = 28'({1'b0, m} + 14'h1) * 28'(x1);
      sum = signed'(18'(prod >> GAIN_FRAC)) + signed'(18'(c)) - signed'(18'(CODE_MID));
      if (sum < 0) begin
         return CODE_ZERO;
      end else if (sum > signed'(18'(CODE_FULL))) begin
         return CODE_FULL;
      end
      return sum[CODE_W-1:0];
   endfunction

   ctrl_state_t s_q, s_d;
   logic fifo_out_valid, fifo_out_ready, fifo_empty;
   logic [WRITE_W-1:0] fifo_out_data;
   write_t head;
   ch_range_t head_rng;
   logic busy, load_outputs_n_low, load_outputs_n_fall, clr_ok, fire;
   logic [CODE_W-1:0] nx1, nc;
   logic [GAIN_W-1:0] nm;

   write_fifo #(
      .WIDTH(WRITE_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo ( // see R17 see R18
      .mclk_i(mclk_i),
      .resetn_i(resetn_i),
      .in_valid_i(wr_valid_i),
      .in_ready_o(wr_ready_o),
      .in_data_i(wr_i),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(fifo_out_ready),
      .out_data_o(fifo_out_data),
      .empty_o(fifo_empty)
   );

   assign wr_dropped_o = wr_valid_i && !wr_ready_o; // see R19
   assign head = write_t'(fifo_out_data);
   assign head_rng = chan_range(head.addr); // see R7
   assign fifo_out_ready = (s_q.state == ST_IDLE); // see R23
   assign busy = (s_q.state != ST_IDLE) || !fifo_empty; // see R6 see R23
   assign busy_n_o = !busy;
   assign load_outputs_n_low = !s_q.load_outputs_n_sync[1];
   assign load_outputs_n_fall = s_q.load_outputs_n_prev && load_outputs_n_low;
   assign clr_ok = s_q.clr_sync[1];
   // Held-low strobe counts again at each end of busy
   assign fire = clr_ok && !busy // see R2 see R8
      && (s_q.pending || load_outputs_n_fall || (load_outputs_n_low && s_q.busy_prev)); // see R4 see R9 see R11

   always_comb begin
      s_d = s_q;
      nx1 = s_q.input_code_reg[s_q.ch];
      nm = s_q.gain[s_q.ch];
      nc = s_q.offset[s_q.ch];
      s_d.load_outputs_n_sync = {s_q.load_outputs_n_sync[0], load_outputs_n_i};
      s_d.clr_sync = {s_q.clr_sync[0], output_clear_n_i};
      s_d.fen_sync = {s_q.fen_sync[0], fifo_enable_i};
      s_d.load_outputs_n_prev = s_q.load_outputs_n_sync[1];
      s_d.busy_prev = busy;

      case (s_q.state)
         ST_IDLE: begin
            if (fifo_out_valid) begin
               s_d.instr = head;
               s_d.ch = head_rng.first;
               s_d.last = head_rng.last;
               s_d.wait_cnt = '0;
               // Special functions and unmapped addresses are consumed as no-ops
               if (head_rng.valid && head.sel != SEL_SPECIAL) begin
                  s_d.state = s_q.fen_sync[1] ? ST_WAIT : ST_CALC; // see R14 see R16
               end
            end
         end
         ST_WAIT: begin
            s_d.wait_cnt = s_q.wait_cnt + 8'h1;
            if (s_q.wait_cnt == OVH_LAST) begin
               s_d.state = ST_CALC; // see R14
            end
         end
         ST_CALC: begin // see R12 see R13
            case (s_q.instr.sel)
               SEL_INPUT: nx1 = s_q.instr.data;
               SEL_OFFSET: nc = s_q.instr.data; // see R20
               SEL_GAIN: nm = s_q.instr.data[GAIN_W-1:0]; // see R20
               default: nx1 = s_q.input_code_reg[s_q.ch];
            endcase
            s_d.input_code_reg[s_q.ch] = nx1;
            s_d.gain[s_q.ch] = nm;
            s_d.offset[s_q.ch] = nc;
            s_d.corrected_code_reg[s_q.ch] = correct(nx1, nm, nc); // see R21
            s_d.changed[s_q.ch] = 1'b1; // see R15
            if (s_q.ch == s_q.last) begin
               s_d.state = ST_IDLE;
            end else begin
               s_d.ch = s_q.ch + 5'h1; // see R7
            end
         end
         default: s_d.state = ST_IDLE;
      endcase

      // Strobe during busy is remembered; ignored entirely under clear
      s_d.pending = (s_q.pending || (load_outputs_n_fall && clr_ok)) && !fire; // see R10 see R4
      if (fire) begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (s_q.changed[i]) begin
               s_d.dac[i] = s_q.corrected_code_reg[i]; // see R15
            end
         end
         s_d.changed = '0;
      end
      s_d.grounded = !clr_ok || (s_q.grounded && !fire); // see R1 see R3
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s_q <= STATE_RESET; // see R22
      end else begin
         s_q <= s_d;
      end
   end

   assign analog_outputs_o = s_q.dac;
   assign analog_outputs_grounded_o = s_q.grounded;

   // Helper: length of the current instruction's busy stretch
   logic [12:0] instr_cyc_q;
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         instr_cyc_q <= '0;
      end else begin
         instr_cyc_q <= (s_q.state == ST_IDLE) ? 13'h0 : instr_cyc_q + 13'h1;
      end
   end

   a_clear_grounds: assert property (@(posedge mclk_i) disable iff (!resetn_i) // see R1
      !clr_ok |=> analog_outputs_grounded_o)
      else $error("outputs not grounded during clear");
   a_clear_keeps_dac: assert property (@(posedge mclk_i) disable iff (!resetn_i) // see R2
      !clr_ok |=> $stable(analog_outputs_o))
      else $error("dac registers changed during clear");
   a_ground_holds: assert property (@(posedge mclk_i) disable iff (!resetn_i) // see R3
      (analog_outputs_grounded_o && !fire) |=> analog_outputs_grounded_o)
      else $error("ground released without load strobe");
   a_load_outputs_n_ignored: assert property (@(posedge mclk_i) disable iff (!resetn_i) // see R4
      (!clr_ok && !s_q.pending) |=> !s_q.pending)
      else $error("strobe stored during clear");
   a_busy_on_write: assert property (@(posedge mclk_i) disable iff (!resetn_i) // see R6
      (wr_valid_i && wr_ready_o) |=> !busy_n_o)
      else $error("busy not asserted after write");
   a_no_update_busy: assert property (@(posedge mclk_i) disable iff (!resetn_i) // see R8
      !busy_n_o |=> $stable(analog_outputs_o))
      else $error("output updated while busy");
   a_pending_served: assert property (@(posedge mclk_i) disable iff (!resetn_i) // see R10
      (s_q.pending && busy_n_o && clr_ok) |=> !s_q.pending ##0 $past(fire))
      else $error("stored strobe not served");
   a_held_low_updates: assert property (@(posedge mclk_i) disable iff (!resetn_i) // see R11
      (load_outputs_n_low && clr_ok && s_q.busy_prev && !busy) |-> fire)
      else $error("held strobe missed end of busy");
   a_busy_bound: assert property (@(posedge mclk_i) disable iff (!resetn_i) // see R12
      instr_cyc_q <= 13'(BUSY_ALL_FIFO_CYC))
      else $error("instruction exceeds busy limit");
   a_single_bound: assert property (@(posedge mclk_i) disable iff (!resetn_i) // see R13
      (s_q.state == ST_CALC && s_q.ch == s_q.last && s_q.instr.addr < ADDR_GROUP_BASE)
      |-> instr_cyc_q < 13'(s_q.fen_sync[1] ? BUSY_1CH_FIFO_CYC : BUSY_1CH_NOFIFO_CYC))
      else $error("single channel busy too long");
   a_range_ends: assert property (@(posedge mclk_i) disable iff (!resetn_i) // see R7
      (s_q.state == ST_CALC && s_q.ch == s_q.last) |=> (s_q.state == ST_IDLE))
      else $error("recompute ran past its range");
   a_range_steps: assert property (@(posedge mclk_i) disable iff (!resetn_i) // see R7
      (s_q.state == ST_CALC && s_q.ch != s_q.last)
      |=> (s_q.ch == $past(s_q.ch) + 5'h1))
      else $error("recompute skipped a channel");
   a_load_ungrounds: assert property (@(posedge mclk_i) disable iff (!resetn_i) // see R9
      (load_outputs_n_fall && clr_ok && !busy) |=> !analog_outputs_grounded_o)
      else $error("idle load strobe did not update outputs");
   a_skip_unchanged: assert property (@(posedge mclk_i) disable iff (!resetn_i) // see R15
      (fire && s_q.changed == '0) |=> $stable(analog_outputs_o))
      else $error("unchanged channel reloaded");
   a_overhead_ends: assert property (@(posedge mclk_i) disable iff (!resetn_i) // see R14
      (s_q.state == ST_WAIT && s_q.wait_cnt == OVH_LAST) |=> (s_q.state == ST_CALC))
      else $error("queue overhead wrong length");
   a_gain_stored: assert property (@(posedge mclk_i) disable iff (!resetn_i) // see R20
      (s_q.state == ST_CALC && s_q.instr.sel == SEL_GAIN)
      |=> (s_q.gain[$past(s_q.ch)] == $past(s_q.instr.data[GAIN_W-1:0])))
      else $error("gain coefficient not stored");
   a_input_stored: assert property (@(posedge mclk_i) disable iff (!resetn_i) // see R6
      (s_q.state == ST_CALC && s_q.instr.sel == SEL_INPUT)
      |=> (s_q.input_code_reg[$past(s_q.ch)] == $past(s_q.instr.data)))
      else $error("input code not stored");

   c_write_taken: cover property (@(posedge mclk_i) disable iff (!resetn_i)
      wr_valid_i && wr_ready_o);
   c_update: cover property (@(posedge mclk_i) disable iff (!resetn_i) fire);
   c_drop: cover property (@(posedge mclk_i) disable iff (!resetn_i) wr_dropped_o);
   c_clear: cover property (@(posedge mclk_i) disable iff (!resetn_i) $fell(clr_ok));
   c_stored_strobe: cover property (@(posedge mclk_i) disable iff (!resetn_i)
      s_q.pending && !busy);
endmodule // dac_update_clear_ctrl

// ### logic/write_fifo.sv
`timescale 1ns/1ps
module write_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 128
) (
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o,
   output logic empty_o
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wptr;
      logic [AW-1:0] rptr;
      logic [AW:0] count;
      logic out_valid;
      logic [WIDTH-1:0] out_data;
   } fifo_state_t;

   fifo_state_t s_q, s_d;
   logic push, pop_mem, drain;

   always_comb begin
      s_d = s_q;
      in_ready_o = (s_q.count != (AW+1)'(DEPTH));
      push = in_valid_i && in_ready_o;
      drain = s_q.out_valid && out_ready_i;
      // Registered read stage refills whenever it empties or is taken
      pop_mem = (s_q.count != '0) && (!s_q.out_valid || drain);
      if (push) begin
         s_d.mem[s_q.wptr] = in_data_i;
         s_d.wptr = s_q.wptr + 1'b1;
      end
      if (pop_mem) begin
         s_d.out_data = s_q.mem[s_q.rptr];
         s_d.rptr = s_q.rptr + 1'b1;
      end
      if (pop_mem) begin
         s_d.out_valid = 1'b1;
      end else if (drain) begin
         s_d.out_valid = 1'b0;
      end
      s_d.count = s_q.count + (AW+1)'(push) - (AW+1)'(pop_mem);
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign out_valid_o = s_q.out_valid;
   assign out_data_o = s_q.out_data;
   assign empty_o = !s_q.out_valid && (s_q.count == '0);

   a_full_refuses: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      (s_q.count == (AW+1)'(DEPTH)) |-> !in_ready_o) // see R19
      else $error("fifo accepts while full");
endmodule // write_fifo

// ### tb/host_model.sv
`timescale 1ns/1ps
module host_model
   import dac_ctrl_pkg::*;
(
   input wire logic mclk_i,
   input wire logic wr_ready_i,
   output logic wr_valid_o,
   output write_t wr_o,
   output logic fifo_enable_o,
   output logic load_outputs_n_o,
   output logic output_clear_n_o
);
   initial begin
      wr_valid_o = 1'b0;
      wr_o = '0;
      fifo_enable_o = 1'b1;
      load_outputs_n_o = 1'b1;
      output_clear_n_o = 1'b1;
   end
   // Valid stays up across calls so writes can go out back to back
   task automatic send(input write_t w, output bit taken);
      @(negedge mclk_i);
      wr_valid_o = 1'b1;
      wr_o = w;
      #1 taken = wr_ready_i;
   endtask
   task automatic idle_bus();
      @(negedge mclk_i);
      wr_valid_o = 1'b0;
      wr_o = ~wr_o;  // Released word must not look like the last one
   endtask
   task automatic pins(input logic fen, input logic ld_n, input logic clr_n);
      @(negedge mclk_i);
      fifo_enable_o = fen;
      load_outputs_n_o = ld_n;
      output_clear_n_o = clr_n;
   endtask
endmodule // host_model

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top
   import dac_ctrl_pkg::*;
   ;
   logic mclk_i;
   logic resetn_i;
   logic wr_valid, wr_ready, wr_dropped, fen, ld_n, clr_n, busy_n, grounded, fe;
   write_t wr;
   logic [NUM_CH-1:0][CODE_W-1:0] outs;
   int x1[NUM_CH], gm[NUM_CH], oc[NUM_CH], x2[NUM_CH], dac[NUM_CH];
   bit chg[NUM_CH];
   bit gnd, tk;
   int fails, cmp_count, n, nt;
   int d[2];
   // Code that puts a channel at its ground reference; board dependent, arbitrary here
   localparam int CLR_TGT = 4096;
   logic [7:0] at[8] = '{8'h20, 8'h24, 8'h05, 8'h23, 8'h30, 8'h21, 8'h24, 8'h1f};

   host_model host_u (.mclk_i(mclk_i), .wr_ready_i(wr_ready), .wr_valid_o(wr_valid),
      .wr_o(wr), .fifo_enable_o(fen), .load_outputs_n_o(ld_n), .output_clear_n_o(clr_n));
   dac_update_clear_ctrl dut_u (.mclk_i(mclk_i), .resetn_i(resetn_i), .wr_valid_i(wr_valid),
      .wr_i(wr), .wr_ready_o(wr_ready), .wr_dropped_o(wr_dropped), .fifo_enable_i(fen),
      .load_outputs_n_i(ld_n), .output_clear_n_i(clr_n), .busy_n_o(busy_n),
      .analog_outputs_grounded_o(grounded), .analog_outputs_o(outs));

   initial mclk_i = 1'b0;
   always #5 mclk_i = ~mclk_i;

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   function automatic write_t mk(logic [1:0] s, logic [7:0] a, logic [13:0] v);
      return '{s, a, v};
   endfunction
   function automatic int calc(int xv, int mv, int cv);
      int r;
      r = (((mv + 1) * xv) >>> 13) + cv - 8192;
      if (r < 0)
         r = 0;
      if (r > 16383)
         r = 16383;
      return r;
   endfunction
   task automatic apply(input write_t w);
      int lo, hi;
      lo = 0;
      hi = (w.addr == ADDR_ALL) ? 31 : -1;
      if (w.addr < ADDR_GROUP_BASE) begin
         lo = w.addr;
         hi = lo;
      end else if (w.addr < ADDR_ALL) begin
         lo = (w.addr - ADDR_GROUP_BASE) * 8;
         hi = lo + 7;
      end
      if (w.sel == SEL_SPECIAL)
         hi = -1;
      for (int i = lo; i <= hi; i++) begin
         if (w.sel == SEL_INPUT)
            x1[i] = w.data;
         if (w.sel == SEL_OFFSET)
            oc[i] = w.data;
         if (w.sel == SEL_GAIN)
            gm[i] = w.data[12:0];
         x2[i] = calc(x1[i], gm[i], oc[i]);
         chg[i] = 1'b1;
      end
   endtask
   task automatic put(input write_t w);
      host_u.send(w, tk);
      check("dropped", wr_dropped, !tk);
      if (tk)
         apply(w);
   endtask
   task automatic wait_idle(output int c);
      c = 0;
      while (busy_n !== 1'b1 && c < 20000) begin
         @(negedge mclk_i);
         c++;
      end
      check("busy_end", c < 20000, 1);
   endtask
   task automatic one(input write_t w, output int c);
      put(w);
      host_u.idle_bus();
      wait_idle(c);
   endtask
   task automatic strobe(input logic clr);
      host_u.pins(fe, 1'b0, clr);
      repeat (2) @(negedge mclk_i);
      host_u.pins(fe, 1'b1, clr);
      repeat (4) @(negedge mclk_i);
   endtask
   task automatic load_m();
      for (int i = 0; i < NUM_CH; i++) begin
         if (chg[i])
            dac[i] = x2[i];
         chg[i] = 1'b0;
      end
      gnd = 1'b0;
   endtask
   task automatic cmp_all();
      for (int i = 0; i < NUM_CH; i++)
         check("out", outs[i], dac[i]);
      check("grounded", grounded, gnd);
   endtask

   initial begin
      #500000;
      fails++;
      final_report();
   end

   initial begin
      resetn_i = 1'b0;
      fe = 1'b1;
      fails = 0;
      cmp_count = 0;
      void'($urandom(66063));
      for (int i = 0; i < NUM_CH; i++) begin
         x1[i] = 8192;
         gm[i] = 8191;
         oc[i] = 8192;
         x2[i] = 8192;
         dac[i] = 8192;
         chg[i] = 1'b0;
      end
      gnd = 1'b1;
      repeat (8) @(posedge mclk_i);
      @(negedge mclk_i);
      resetn_i = 1'b1;
      @(negedge mclk_i);
      cmp_all();
      check("idle_busy", busy_n, 1'b1);
      check("ready", wr_ready, 1'b1);
      for (int k = 1; k >= 0; k--) begin
         fe = k[0];
         host_u.pins(fe, 1'b1, 1'b1);
         repeat (4) @(negedge mclk_i);
         one(mk(SEL_INPUT, 8'($urandom_range(31)), 14'($urandom)), d[k]);
         check("busy_time", d[k] > 0 && d[k] <= (k ? BUSY_1CH_FIFO_CYC : BUSY_1CH_NOFIFO_CYC), 1);
         strobe(1'b1);
         load_m();
         cmp_all();
      end
      check("fifo_overhead", d[1] - d[0], FIFO_OVH_CYC);
      fe = 1'b1;
      host_u.pins(fe, 1'b1, 1'b1);
      repeat (4) @(negedge mclk_i);
      for (int k = 0; k < 8; k++) begin
         one(mk(2'((k + 1) % 4), at[k], 14'($urandom)), n);
         check("busy_time", n > 0 && n <= BUSY_ALL_FIFO_CYC, 1);
      end
      strobe(1'b1);
      load_m();
      cmp_all();
      put(mk(SEL_INPUT, 8'h22, 14'($urandom)));
      host_u.idle_bus();
      strobe(1'b1);
      check("busy_held", busy_n, 1'b0);
      cmp_all();
      wait_idle(n);
      repeat (3) @(negedge mclk_i);
      load_m();
      cmp_all();
      host_u.pins(fe, 1'b0, 1'b1);
      repeat (4) @(negedge mclk_i);
      for (int k = 0; k < 3; k++) begin
         put(mk(SEL_INPUT, 8'(k * 9), 14'($urandom)));
         check("taken", tk, 1'b1);
      end
      host_u.idle_bus();
      wait_idle(n);
      check("busy_span", n >= 3 * FIFO_OVH_CYC, 1);
      repeat (3) @(negedge mclk_i);
      load_m();
      cmp_all();
      one(mk(SEL_OFFSET, 8'h24, 14'($urandom)), n);
      repeat (3) @(negedge mclk_i);
      load_m();
      cmp_all();
      host_u.pins(fe, 1'b1, 1'b1);
      one(mk(SEL_INPUT, 8'h0e, 14'($urandom)), n);
      host_u.pins(fe, 1'b1, 1'b0);
      repeat (4) @(negedge mclk_i);
      gnd = 1'b1;
      cmp_all();
      strobe(1'b0);
      cmp_all();
      host_u.pins(fe, 1'b1, 1'b1);
      repeat (4) @(negedge mclk_i);
      cmp_all();
      strobe(1'b1);
      load_m();
      cmp_all();
      nt = 0;
      for (int k = 0; k < 150; k++) begin
         put(mk(SEL_INPUT, 8'($urandom_range(31)), 14'($urandom)));
         nt += tk;
      end
      host_u.idle_bus();
      check("fill_taken", nt >= FIFO_DEPTH && nt < 150, 1);
      wait_idle(n);
      one(mk(SEL_GAIN, 8'h03, 14'h0fff), n);
      one(mk(SEL_OFFSET, 8'h03, OFFSET_DEFAULT), n);
      // Software clear: invert the correction, rounding up so the floor lands on target
      nt = ((CLR_TGT - oc[3] + 8192) * 8192 + gm[3]) / (gm[3] + 1);
      one(mk(SEL_INPUT, 8'h03, 14'(nt)), n);
      strobe(1'b1);
      load_m();
      cmp_all();
      check("soft_clear", outs[3], CLR_TGT);
      final_report();
   end
endmodule // tb_top
